/* File: design/unknown_fwd_and_mac_ctrl.v */
// Operation
// - unknown multicast enable set: send such frames to the multicast port mask
// - unknown multicast enable clear: no mask redirection for such frames
// - multicast mask bits 6:0, bit 0 is port 1, one forwards
// - unknown VLAN enable set: send such frames to the VLAN port mask
// - unknown VLAN enable clear: no mask redirection for such frames
// - VLAN mask bits 6:0, bit 0 is port 1, one forwards
// - alternate back-off affects half-duplex ports only
// - length check on: drop frames whose length mismatches field below 1500
// - length check off: no length comparison at all
// - drop mode set: drop pause type or pause address frames
// - drop mode clear: drop only frames with both pause type and address
// - aggressive back-off on: aggressive half-duplex back-pressure back-off
// - precedence: unknown VLAN, then unknown unicast, then unknown multicast
//
// Register access over AXI4-Lite is this design's own decision.
`include "fwd_ctrl_defs.vh"
module unknown_fwd_and_mac_ctrl (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire unk_vlan_i,
  input wire unk_ucast_i,
  input wire unk_mcast_i,
  input wire ucast_fwd_en_i,
  input wire [6:0] ucast_ports_i,
  input wire [15:0] type_len_i,
  input wire [15:0] actual_len_i,
  input wire [47:0] da_i,
  input wire [6:0] half_duplex_i,
  output reg redirect_o,
  output reg [6:0] redirect_ports_o,
  output reg len_drop_o,
  output reg fc_drop_o,
  output reg [6:0] alt_backoff_o,
  output reg aggr_backoff_o
);
  reg mcast_en;
  reg [6:0] mcast_ports;
  reg vlan_en;
  reg [6:0] vlan_ports;
  reg [7:0] mac_ctrl0;
  reg aw_held;
  reg [11:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire next_redirect;
  wire [6:0] next_redirect_ports;
  wire next_len_drop;
  wire next_fc_drop;

  // full byte addresses kept here so that only the word index is compared
  localparam [11:0] ADDR_MCAST = `OFS_UNK_MCAST;
  localparam [11:0] ADDR_VLAN = `OFS_UNK_VLAN;
  localparam [11:0] ADDR_CTRL0 = `OFS_MAC_CTRL0;

  // address bits 1:0 are ignored: any access inside the word selects the register
  function hit_mcast;
    input [11:0] addr;
    begin
      hit_mcast = (addr[11:2] == ADDR_MCAST[11:2]);
    end
  endfunction

  function hit_vlan;
    input [11:0] addr;
    begin
      hit_vlan = (addr[11:2] == ADDR_VLAN[11:2]);
    end
  endfunction

  function hit_ctrl0;
    input [11:0] addr;
    begin
      hit_ctrl0 = (addr[11:2] == ADDR_CTRL0[11:2]);
    end
  endfunction

  // shared by the write response and the read response
  function mapped;
    input [11:0] addr;
    begin
      mapped = hit_mcast(addr) || hit_vlan(addr) || hit_ctrl0(addr);
    end
  endfunction

  // address and data are latched independently, so either may arrive first
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data = w_held ? w_data : s_axi_wdata_i;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  assign do_write = (aw_held || (s_axi_awvalid_i && s_axi_awready_o)) &&
                    (w_held || (s_axi_wvalid_i && s_axi_wready_o));

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i)
          s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // reserved bits 30:7 of the two mask registers and 31:8 of MAC control 0 have no storage, so writes there vanish
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcast_en <= 1'b0;
      mcast_ports <= 7'h00;
      vlan_en <= 1'b0;
      vlan_ports <= 7'h00;
      mac_ctrl0 <= `MC0_RST;
    end else if (do_write) begin
      if (hit_mcast(wr_addr)) begin
        if (wr_strb[3])
          mcast_en <= wr_data[`FWD_EN_BIT];
        if (wr_strb[0])
          mcast_ports <= wr_data[6:0];
      end
      if (hit_vlan(wr_addr)) begin
        if (wr_strb[3])
          vlan_en <= wr_data[`FWD_EN_BIT];
        if (wr_strb[0])
          vlan_ports <= wr_data[6:0];
      end
      if (hit_ctrl0(wr_addr) && wr_strb[0])
        mac_ctrl0 <= wr_data[7:0] & `MC0_RW_MASK;
    end
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      // unmapped words read zero so software never sees stale data
      if (hit_mcast(s_axi_araddr_i))
        s_axi_rdata_o <= {mcast_en, 24'h000000, mcast_ports};
      else if (hit_vlan(s_axi_araddr_i))
        s_axi_rdata_o <= {vlan_en, 24'h000000, vlan_ports};
      else if (hit_ctrl0(s_axi_araddr_i))
        s_axi_rdata_o <= {24'h000000, mac_ctrl0};
      else
        s_axi_rdata_o <= 32'h00000000;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  frame_policy u_policy (
    .unk_vlan_i(unk_vlan_i),
    .unk_ucast_i(unk_ucast_i),
    .unk_mcast_i(unk_mcast_i),
    .ucast_fwd_en_i(ucast_fwd_en_i),
    .ucast_ports_i(ucast_ports_i),
    .mcast_fwd_en_i(mcast_en),
    .mcast_ports_i(mcast_ports),
    .vlan_fwd_en_i(vlan_en),
    .vlan_ports_i(vlan_ports),
    .len_check_i(mac_ctrl0[`MC0_LEN_CHECK]),
    .fc_drop_mode_i(mac_ctrl0[`MC0_FC_DROP_MODE]),
    .type_len_i(type_len_i),
    .actual_len_i(actual_len_i),
    .da_i(da_i),
    .redirect_o(next_redirect),
    .redirect_ports_o(next_redirect_ports),
    .len_drop_o(next_len_drop),
    .fc_drop_o(next_fc_drop)
  );

  // decisions are registered: one cycle from frame inputs to verdict
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      redirect_o <= 1'b0;
      redirect_ports_o <= 7'h00;
      len_drop_o <= 1'b0;
      fc_drop_o <= 1'b0;
      alt_backoff_o <= 7'h00;
      aggr_backoff_o <= 1'b0;
    end else begin
      redirect_o <= next_redirect;
      redirect_ports_o <= next_redirect_ports;
      len_drop_o <= next_len_drop;
      fc_drop_o <= next_fc_drop;
      alt_backoff_o <= {7{mac_ctrl0[`MC0_ALT_BACKOFF]}} & half_duplex_i;
      aggr_backoff_o <= mac_ctrl0[`MC0_AGGR_BACKOFF];
    end
  end
endmodule

/* File: design/fwd_ctrl_defs.vh */
`ifndef FWD_CTRL_DEFS_VH
`define FWD_CTRL_DEFS_VH
`define OFS_UNK_MCAST 12'h324
`define OFS_UNK_VLAN 12'h328
`define OFS_MAC_CTRL0 12'h330
`define FWD_EN_BIT 31
`define PORT_MASK_W 7
`define MC0_ALT_BACKOFF 7
`define MC0_LEN_CHECK 3
`define MC0_RSVD2 2
`define MC0_FC_DROP_MODE 1
`define MC0_AGGR_BACKOFF 0
`define UNK_RST 32'h00000000
`define MC0_RST 8'h04
`define MC0_RW_MASK 8'hff
`define LEN_CHECK_LIMIT 16'h05dc
`define FC_ETHERTYPE 16'h8808
`define FC_DA 48'h0180c2000001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: design/frame_policy.v */
`include "fwd_ctrl_defs.vh"
// per-frame decisions from the configuration bits
module frame_policy (
  input wire unk_vlan_i,
  input wire unk_ucast_i,
  input wire unk_mcast_i,
  input wire ucast_fwd_en_i,
  input wire [6:0] ucast_ports_i,
  input wire mcast_fwd_en_i,
  input wire [6:0] mcast_ports_i,
  input wire vlan_fwd_en_i,
  input wire [6:0] vlan_ports_i,
  input wire len_check_i,
  input wire fc_drop_mode_i,
  input wire [15:0] type_len_i,
  input wire [15:0] actual_len_i,
  input wire [47:0] da_i,
  output reg redirect_o,
  output reg [6:0] redirect_ports_o,
  output wire len_drop_o,
  output wire fc_drop_o
);
  wire is_fc_type;
  wire is_fc_da;
  assign is_fc_type = (type_len_i == `FC_ETHERTYPE);
  assign is_fc_da = (da_i == `FC_DA);
  // only the top-precedence category is used, even when its enable is clear
  always @* begin
    redirect_o = 1'b0;
    redirect_ports_o = 7'h00;
    if (unk_vlan_i) begin
      redirect_o = vlan_fwd_en_i;
      redirect_ports_o = vlan_fwd_en_i ? vlan_ports_i : 7'h00;
    end else if (unk_ucast_i) begin
      redirect_o = ucast_fwd_en_i;
      redirect_ports_o = ucast_fwd_en_i ? ucast_ports_i : 7'h00;
    end else if (unk_mcast_i) begin
      redirect_o = mcast_fwd_en_i;
      redirect_ports_o = mcast_fwd_en_i ? mcast_ports_i : 7'h00;
    end
  end
  assign len_drop_o = len_check_i && (type_len_i < `LEN_CHECK_LIMIT) &&
                      (actual_len_i != type_len_i);
  assign fc_drop_o = fc_drop_mode_i ? (is_fc_type | is_fc_da)
                                    : (is_fc_type & is_fc_da);
endmodule

/* File: sim/fwd_ctrl_monitor.sv */
`include "fwd_ctrl_defs.vh"
module fwd_ctrl_monitor (
  input wire mclk_i,
  input wire rst_b_i,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  input wire unk_vlan_i,
  input wire unk_ucast_i,
  input wire unk_mcast_i,
  input wire ucast_fwd_en_i,
  input wire [6:0] ucast_ports_i,
  input wire [15:0] type_len_i,
  input wire [15:0] actual_len_i,
  input wire [47:0] da_i,
  input wire [6:0] half_duplex_i,
  input wire redirect_o,
  input wire [6:0] redirect_ports_o,
  input wire len_drop_o,
  input wire fc_drop_o,
  input wire [6:0] alt_backoff_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_half_only: assert property ((alt_backoff_o & ~$past(half_duplex_i)) == 7'h00)
    else $error("alternate back-off on full duplex port");
  a_len_cause: assert property (len_drop_o |-> $past(type_len_i) < `LEN_CHECK_LIMIT &&
    $past(actual_len_i) != $past(type_len_i)) else $error("length drop without cause");
  // the reset guard skips the first edge after release, where outputs were still forced low
  a_fc_both: assert property ($past(rst_b_i) && $past(type_len_i) == `FC_ETHERTYPE &&
    $past(da_i) == `FC_DA |-> fc_drop_o) else $error("pause frame not dropped");
  a_idle_redirect: assert property (!$past(unk_vlan_i || unk_ucast_i || unk_mcast_i)
    |-> !redirect_o) else $error("redirect of a known frame");
  a_ucast_prio: assert property ($past(rst_b_i) && $past(!unk_vlan_i && unk_ucast_i)
    |-> redirect_o == $past(ucast_fwd_en_i) && (!redirect_o ||
    redirect_ports_o == $past(ucast_ports_i))) else $error("unicast precedence broken");
  c_fc_drop: cover property (fc_drop_o);
  c_len_drop: cover property (len_drop_o);
  c_redirect: cover property (redirect_o && unk_mcast_i);
endmodule
bind unknown_fwd_and_mac_ctrl fwd_ctrl_monitor i_fwd_ctrl_monitor (.*);

/* File: sim/mgmt_master.sv */
module mgmt_master (
  input wire mclk_i,
  input wire awready_i,
  input wire wready_i,
  input wire bvalid_i,
  input wire [1:0] bresp_i,
  input wire arready_i,
  input wire rvalid_i,
  input wire [31:0] rdata_i,
  input wire [1:0] rresp_i,
  output logic [11:0] awaddr_o,
  output logic awvalid_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  output logic bready_o,
  output logic [11:0] araddr_o,
  output logic arvalid_o,
  output logic rready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // no latency is assumed anywhere: only the bench watchdog ends a stuck wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge mclk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
    end while ((awvalid_o && !awready_i) || (wvalid_o && !wready_i));
    do @(posedge mclk_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge mclk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge mclk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

/* File: sim/test_unknown_fwd_and_mac_ctrl.sv */
`include "fwd_ctrl_defs.vh"
module test_unknown_fwd_and_mac_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, unk_vlan_i, unk_ucast_i, unk_mcast_i, ucast_fwd_en_i;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, lfsr, mc, vl, got;
  logic [3:0] s_axi_wstrb_i;
  logic [6:0] ucast_ports_i, half_duplex_i;
  logic [15:0] type_len_i, actual_len_i;
  logic [47:0] da_i;
  logic [7:0] c0;
  logic [1:0] resp;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire redirect_o, len_drop_o, fc_drop_o, aggr_backoff_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [6:0] redirect_ports_o, alt_backoff_o;
  int fail_count, samples_checked;
  unknown_fwd_and_mac_ctrl i_unknown_fwd_and_mac_ctrl (.*);
  mgmt_master i_mgmt_master (.mclk_i, .awready_i(s_axi_awready_o), .wready_i(s_axi_wready_o),
    .bvalid_i(s_axi_bvalid_o), .bresp_i(s_axi_bresp_o), .arready_i(s_axi_arready_o),
    .rvalid_i(s_axi_rvalid_o), .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o),
    .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i), .wdata_o(s_axi_wdata_i),
    .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i), .bready_o(s_axi_bready_i),
    .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .rready_o(s_axi_rready_i));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] route_exp();
    if (unk_vlan_i) return {vl[31], vl[6:0]};
    if (unk_ucast_i) return {ucast_fwd_en_i, ucast_ports_i};
    if (unk_mcast_i) return {mc[31], mc[6:0]};
    return 8'h00;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    i_mgmt_master.rd(a, got, resp);
    check(got, d);
    check(resp, r);
  endtask
  task automatic reg_rw(input logic [11:0] a, input logic [31:0] d, input logic [31:0] keep);
    i_mgmt_master.wr(a, d, 4'hf, resp);
    check(resp, `RESP_OKAY);
    rd_chk(a, d & keep, `RESP_OKAY);
  endtask
  // lengths straddle the 1499/1500 boundary and pause fields appear often
  task automatic frame;
    logic [15:0] tl;
    logic [7:0] e;
    lfsr = step(lfsr);
    tl = lfsr[18] ? `FC_ETHERTYPE : (lfsr[31] ? 16'h05db + lfsr[19] : {5'h00, lfsr[29:19]});
    @(posedge mclk_i);
    {unk_vlan_i, unk_ucast_i, unk_mcast_i, ucast_fwd_en_i, ucast_ports_i} <= lfsr[10:0];
    half_duplex_i <= lfsr[17:11];
    type_len_i <= tl;
    actual_len_i <= lfsr[30] ? tl : tl + 16'h0001;
    da_i <= lfsr[20] ? `FC_DA : {lfsr[15:0], lfsr};
    @(posedge mclk_i);
    #1;
    e = route_exp();
    check(redirect_o, e[7]);
    if (e[7]) check(redirect_ports_o, e[6:0]);
    check(len_drop_o, c0[3] && tl < `LEN_CHECK_LIMIT && actual_len_i != tl);
    check(fc_drop_o, c0[1] ? (tl == `FC_ETHERTYPE || da_i == `FC_DA) :
      (tl == `FC_ETHERTYPE && da_i == `FC_DA));
    check(alt_backoff_o, c0[7] ? half_duplex_i : 7'h00);
    check(aggr_backoff_o, c0[0]);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    fail_count = 0;
    samples_checked = 0;
    lfsr = 32'h00008077;
    rst_b_i = 1'b0;
    {unk_vlan_i, unk_ucast_i, unk_mcast_i, ucast_fwd_en_i, ucast_ports_i} = '0;
    {half_duplex_i, type_len_i, actual_len_i, da_i} = '0;
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd_chk(`OFS_UNK_MCAST, `UNK_RST, `RESP_OKAY);
    rd_chk(`OFS_UNK_VLAN, `UNK_RST, `RESP_OKAY);
    rd_chk(`OFS_MAC_CTRL0, {24'h000000, `MC0_RST}, `RESP_OKAY);
    rd_chk(12'h32c, 32'h00000000, `RESP_SLVERR);
    i_mgmt_master.wr(12'h32c, 32'hffffffff, 4'hf, resp);
    check(resp, `RESP_SLVERR);
    // partial strobes: the low lane must leave the enable alone, the top lane the ports
    i_mgmt_master.wr(`OFS_UNK_MCAST, 32'h8000007f, 4'h1, resp);
    check(resp, `RESP_OKAY);
    rd_chk(`OFS_UNK_MCAST, 32'h0000007f, `RESP_OKAY);
    i_mgmt_master.wr(`OFS_UNK_MCAST, 32'h80000000, 4'h8, resp);
    check(resp, `RESP_OKAY);
    rd_chk(`OFS_UNK_MCAST, 32'h8000007f, `RESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      lfsr = step(lfsr);
      mc = (k == 0) ? 32'h80000000 : lfsr;
      reg_rw(`OFS_UNK_MCAST, mc, 32'h8000007f);
      mc = mc & 32'h8000007f;
      lfsr = step(lfsr);
      vl = (k == 0) ? 32'hffffffff : lfsr;
      reg_rw(`OFS_UNK_VLAN, vl, 32'h8000007f);
      vl = vl & 32'h8000007f;
      lfsr = step(lfsr);
      c0 = lfsr[7:0];
      reg_rw(`OFS_MAC_CTRL0, {24'h000000, c0}, 32'h000000ff);
      repeat (12) frame();
    end
    complete_run();
  end
endmodule
